// ---- flash_seq_pkg.sv ----
/*
  Constants and carrier types for the flash self-programming sequencer.
  Assumes a 16-bit processor write port and a flash macro with start/done handshake.
*/
package flash_seq_pkg;
  localparam int          DATA_W          = 16;
  localparam int          ADDR_W          = 24;
  localparam int          ADDR_HIGH_W     = 8;
  localparam int          WORD_W          = 24;
  localparam int          START_BIT_POS   = 15;
  localparam int          OP_BIT_POS      = 0;
  localparam logic [7:0]  KEY_FIRST       = 8'h55;
  localparam logic [7:0]  KEY_SECOND      = 8'hAA;
  localparam logic [1:0]  SEL_CONTROL     = 2'h0;
  localparam logic [1:0]  SEL_KEY         = 2'h1;
  localparam logic [1:0]  SEL_ADDR_HIGH   = 2'h2;
  localparam logic [1:0]  SEL_ADDR_LOW    = 2'h3;
  localparam logic [15:0] CONTROL_RESET   = 16'h0000;
  localparam logic [23:0] ADDR_RESET      = 24'h00_0000;
  localparam logic [23:0] PAIR_ALIGN_MASK = 24'h00_0003;
  localparam logic [23:0] PAIR_ALIGN_VAL  = 24'h00_0002;
  localparam int          PULSE_CYCLES    = 1;

  typedef enum logic { OP_PROGRAM, OP_ERASE } flash_op_t;

  typedef struct packed {
    logic        en;
    logic [1:0]  sel;
    logic [15:0] data;
  } reg_write_t;

  typedef struct packed {
    logic        start;
    flash_op_t   op;
    logic [23:0] addr;
    logic [47:0] data;
  } flash_cmd_t;
endpackage

// ---- unlock_tracker.sv ----
/*
  Unlock key tracker: arms after the two key values on consecutive writes.
  Assumes one-cycle write strobes from the processor port on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module unlock_tracker
  import flash_seq_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  input  wire reg_write_t wr_i,
  input  wire logic       consume_i,
  output logic            armed_o
);
  logic first_reg;
  logic first_next;
  logic armed_reg;
  logic armed_next;
  wire  key_wr     = wr_i.en && (wr_i.sel == SEL_KEY);
  wire  key_first  = key_wr && (wr_i.data[7:0] == KEY_FIRST);
  wire  key_second = key_wr && (wr_i.data[7:0] == KEY_SECOND);

  // Any other write breaks a partial sequence
  always_comb
  begin
    first_next = first_reg;
    armed_next = armed_reg;
    if (wr_i.en)
    begin
      first_next = key_first;
      armed_next = key_second && first_reg;
      if (wr_i.sel == SEL_CONTROL)
      begin
        armed_next = 1'b0;
      end
    end
    if (consume_i)
    begin
      armed_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      first_reg <= 1'b0;
      armed_reg <= 1'b0;
    end
    else
    begin
      first_reg <= first_next;
      armed_reg <= armed_next;
    end
  end

  assign armed_o = armed_reg;
endmodule
`default_nettype wire

// ---- flash_self_program_sequencer.sv ----
/*
  Flash self-programming sequencer: unlock, address, start, stall, self-clearing start bit.
  Assumes a flash macro that pulses done when erase or program finishes.
*/
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_sequencer
  import flash_seq_pkg::*;
(
  input  wire logic                clk_sys_i,
  input  wire logic                arst_n_i,
  input  wire logic                wr_en_i,
  input  wire logic [1:0]          wr_sel_i,
  input  wire logic [DATA_W-1:0]   wr_data_i,
  input  wire logic [2*WORD_W-1:0] prog_data_i,
  input  wire logic                flash_done_i,
  output logic [DATA_W-1:0]        flash_control_reg_o,
  output logic [ADDR_W-1:0]        target_addr_o,
  output logic                     stall_o,
  output logic                     refused_o,
  output flash_cmd_t               flash_cmd_o
);
  typedef enum logic [1:0] { ST_IDLE, ST_LAUNCH, ST_BUSY } seq_state_t;

  seq_state_t        state_reg;
  seq_state_t        state_next;
  logic [15:0]       flash_control_reg;
  logic [15:0]       flash_control_next;
  logic [7:0]        flash_target_addr_high;
  logic [15:0]       flash_target_addr_low;
  logic              stall_reg;
  logic              refused_reg;
  logic              refused_next;
  flash_cmd_t        cmd_reg;
  flash_cmd_t        cmd_next;
  logic              armed;
  reg_write_t        wr;

  assign wr = {wr_en_i, wr_sel_i, wr_data_i};

  wire [ADDR_W-1:0] target_addr = {flash_target_addr_high, flash_target_addr_low};
  wire              ctl_wr      = wr_en_i && (wr_sel_i == SEL_CONTROL) && (state_reg == ST_IDLE);
  wire              start_req   = ctl_wr && wr_data_i[START_BIT_POS];
  wire              op_erase    = wr_data_i[OP_BIT_POS];
  wire              pair_ok     = (target_addr & PAIR_ALIGN_MASK) == PAIR_ALIGN_VAL;
  wire              go          = start_req && armed && (op_erase || pair_ok);
  wire              consume     = start_req;
  wire              stall_next  = (state_next != ST_IDLE);

  unlock_tracker u_unlock
  (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .wr_i      (wr),
    .consume_i (consume),
    .armed_o   (armed)
  );

  // Sequencer
  always_comb
  begin
    state_next         = state_reg;
    flash_control_next = flash_control_reg;
    refused_next       = refused_reg;
    cmd_next           = cmd_reg;
    cmd_next.start     = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        if (ctl_wr)
        begin
          flash_control_next                = wr_data_i;
          flash_control_next[START_BIT_POS] = go;
          refused_next                      = start_req && !go;
        end
        if (go)
        begin
          cmd_next.start = 1'b1;
          cmd_next.op    = op_erase ? OP_ERASE : OP_PROGRAM;
          cmd_next.addr  = target_addr;
          cmd_next.data  = prog_data_i;
          state_next     = ST_LAUNCH;
        end
      end
      ST_LAUNCH:
      begin
        state_next = ST_BUSY;
      end
      ST_BUSY:
      begin
        if (flash_done_i)
        begin
          flash_control_next[START_BIT_POS] = 1'b0;
          state_next                        = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Control register with self-clearing start bit
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      flash_control_reg <= CONTROL_RESET;
    end
    else
    begin
      flash_control_reg <= flash_control_next;
    end
  end

  // Refusal flag
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      refused_reg <= 1'b0;
    end
    else
    begin
      refused_reg <= refused_next;
    end
  end

  // Flash command register
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cmd_reg <= '0;
    end
    else
    begin
      cmd_reg <= cmd_next;
    end
  end

  // Processor stall
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      stall_reg <= 1'b0;
    end
    else
    begin
      stall_reg <= stall_next;
    end
  end

  // Address registers, locked while busy
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      flash_target_addr_high <= ADDR_RESET[23:16];
      flash_target_addr_low  <= ADDR_RESET[15:0];
    end
    else if (wr_en_i && (state_reg == ST_IDLE))
    begin
      if (wr_sel_i == SEL_ADDR_HIGH)
      begin
        flash_target_addr_high <= wr_data_i[7:0];
      end
      if (wr_sel_i == SEL_ADDR_LOW)
      begin
        flash_target_addr_low <= wr_data_i;
      end
    end
  end

  logic [ADDR_W-1:0] addr_out_reg;
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      addr_out_reg <= ADDR_RESET;
    end
    else
    begin
      addr_out_reg <= target_addr;
    end
  end

  assign flash_control_reg_o = flash_control_reg;
  assign target_addr_o       = addr_out_reg;
  assign stall_o             = stall_reg;
  assign refused_o           = refused_reg;
  assign flash_cmd_o         = cmd_reg;
endmodule
`default_nettype wire

// ---- flash_seq_properties.sv ----
/* Port checker for the flash sequencer.
   Bound to the top module; async active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module flash_seq_properties
  import flash_seq_pkg::*;
(
  input wire logic              clk_sys_i,
  input wire logic              arst_n_i,
  input wire logic              wr_en_i,
  input wire logic [1:0]        wr_sel_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic [47:0]       prog_data_i,
  input wire logic              flash_done_i,
  input wire logic [DATA_W-1:0] flash_control_reg_o,
  input wire logic [ADDR_W-1:0] target_addr_o,
  input wire logic              stall_o,
  input wire logic              refused_o,
  input wire flash_cmd_t        flash_cmd_o
);
  logic [1:0] last_reg;
  logic [1:0] prev_reg;
  wire key_w = wr_en_i && wr_sel_i == SEL_KEY;
  wire go_w = wr_en_i && wr_sel_i == SEL_CONTROL && wr_data_i[15] && !stall_o;
  wire ok_w = last_reg == 2'h2 && prev_reg == 2'h1 && (wr_data_i[0] || target_addr_o[1:0] == 2'h2);
  // Key codes of the last two writes
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i)
      {last_reg, prev_reg} <= 4'h0;
    else if (wr_en_i)
      {last_reg, prev_reg} <= {key_w && wr_data_i[7:0] == KEY_SECOND,
                               key_w && wr_data_i[7:0] == KEY_FIRST, last_reg};
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  launch_gate_a: assert property (go_w |=> flash_cmd_o.start == $past(ok_w))
    else $error("launch gate");
  refuse_flag_a: assert property (go_w |=> refused_o == !$past(ok_w))
    else $error("refusal flag");
  pair_align_a: assert property (flash_cmd_o.start && flash_cmd_o.op == OP_PROGRAM
    |-> flash_cmd_o.addr[1:0] == 2'h2) else $error("misaligned");
  op_select_a: assert property (go_w ##1 flash_cmd_o.start
    |-> flash_cmd_o.op == flash_op_t'($past(wr_data_i[0]))) else $error("wrong op");
  addr_join_a: assert property (flash_cmd_o.start |-> flash_cmd_o.addr == target_addr_o)
    else $error("address");
  stall_hold_a: assert property (stall_o && !(flash_done_i && $past(stall_o)) |=> stall_o)
    else $error("stall dropped");
  start_clear_a: assert property (stall_o && $past(stall_o) && flash_done_i
    |=> !stall_o && !flash_control_reg_o[15]) else $error("start not cleared");
  start_mirror_a: assert property (stall_o == flash_control_reg_o[15])
    else $error("stall vs start");
  cover property (go_w ##1 flash_cmd_o.start);
  cover property (go_w ##1 refused_o);
  cover property (stall_o ##1 !stall_o);
endmodule
bind flash_self_program_sequencer flash_seq_properties u_flash_seq_properties (
  .clk_sys_i, .arst_n_i, .wr_en_i, .wr_sel_i, .wr_data_i, .prog_data_i, .flash_done_i,
  .flash_control_reg_o, .target_addr_o, .stall_o, .refused_o, .flash_cmd_o);
`default_nettype wire

// ---- flash_self_program_sequencer_tb.sv ----
/* Bench for the flash sequencer.
   Drives the write port itself; checker is bound to the design. */
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_sequencer_tb
  import flash_seq_pkg::*;
;
  logic clk_sys_i = 1'h0, arst_n_i = 1'h0, wr_en_i = 1'h0, flash_done_i = 1'h0;
  logic [1:0]  wr_sel_i = 2'h0;
  logic [15:0] wr_data_i = 16'h0000;
  logic [47:0] prog_data_i = 48'h0000_0000_0000;
  logic [15:0] flash_control_reg_o;
  logic [23:0] target_addr_o;
  logic        stall_o, refused_o;
  flash_cmd_t  flash_cmd_o;
  int mismatches = 0, compares = 0, cycles = 0;
  flash_self_program_sequencer u_flash_self_program_sequencer (.clk_sys_i, .arst_n_i,
    .wr_en_i, .wr_sel_i, .wr_data_i, .prog_data_i, .flash_done_i, .flash_control_reg_o,
    .target_addr_o, .stall_o, .refused_o, .flash_cmd_o);
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
    if (++cycles == 2000)
    begin
      mismatches++;
      print_verdict();
    end
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [127:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [15:0] d);
    wr_en_i <= 1'h1;
    wr_sel_i <= s;
    wr_data_i <= d;
    @(posedge clk_sys_i);
  endtask
  // Address, keys, start; skip drops first key, brk inserts a write
  task automatic run(input logic [23:0] a, input logic [15:0] c, input logic skip, brk, go);
    prog_data_i <= {a, ~a};
    wr(SEL_ADDR_HIGH, {8'h00, a[23:16]});
    wr(SEL_ADDR_LOW, a[15:0]);
    if (!skip)
      wr(SEL_KEY, {8'h00, KEY_FIRST});
    if (brk)
      wr(SEL_ADDR_LOW, a[15:0]);
    wr(SEL_KEY, {8'h00, KEY_SECOND});
    wr(SEL_CONTROL, c);
    wr_en_i <= 1'h0;
    #1 chk({target_addr_o, flash_cmd_o.start, stall_o, flash_control_reg_o[15], refused_o},
           {a, go, go, go, !go});
    if (go)
    begin
      chk({flash_cmd_o.op, flash_cmd_o.addr, flash_cmd_o.data}, {c[0], a, a, ~a});
      repeat (3) @(posedge clk_sys_i);
      #1 chk({flash_cmd_o.start, flash_control_reg_o[15], stall_o}, 3'h3);
      @(posedge clk_sys_i);
      flash_done_i <= 1'h1;
      @(posedge clk_sys_i);
      flash_done_i <= 1'h0;
      #1 chk({flash_control_reg_o[15], stall_o}, 2'h0);
    end
    @(posedge clk_sys_i);
  endtask
  task automatic t_program();
    run(24'h12_3400, 16'h8001, 1'h0, 1'h0, 1'h1);
    run(24'h12_3456, 16'h8000, 1'h0, 1'h0, 1'h1);
    $display("program test done");
  endtask
  task automatic t_erase();
    run(24'h00_0401, 16'h8001, 1'h0, 1'h0, 1'h1);
    $display("erase test done");
  endtask
  task automatic t_refuse();
    run(24'h00_0004, 16'h8000, 1'h0, 1'h0, 1'h0);
    run(24'h00_0006, 16'h8000, 1'h1, 1'h0, 1'h0);
    run(24'h00_000A, 16'h8000, 1'h0, 1'h1, 1'h0);
    $display("refusal test done");
  endtask
  // Reset in mid-operation, then a start without keys
  task automatic t_reset();
    wr(SEL_KEY, {8'h00, KEY_FIRST});
    wr(SEL_KEY, {8'h00, KEY_SECOND});
    wr(SEL_CONTROL, 16'h8001);
    wr_en_i <= 1'h0;
    #1 chk(stall_o, 1'h1);
    @(posedge clk_sys_i);
    arst_n_i <= 1'h0;
    #1 chk({flash_control_reg_o, target_addr_o, stall_o, refused_o, flash_cmd_o.start},
           43'h0);
    @(posedge clk_sys_i);
    arst_n_i <= 1'h1;
    wr(SEL_CONTROL, 16'h8001);
    wr_en_i <= 1'h0;
    #1 chk({stall_o, flash_control_reg_o[15], flash_cmd_o.start, refused_o}, 4'h1);
    @(posedge clk_sys_i);
    $display("reset test done");
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys_i);
    arst_n_i <= 1'h1;
    @(posedge clk_sys_i);
    #1 chk({flash_control_reg_o, target_addr_o, stall_o, refused_o}, 42'h0);
    @(posedge clk_sys_i);
    t_program();
    t_erase();
    t_refuse();
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
